// File: design/io_register_space_decoder.sv
// i/o register space decoder: i/o and data-space access, bit operations, flag registers
`timescale 1ns/1ps
`include "io_space_map.svh"

module io_register_space_decoder (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic acc_valid_i,
    input wire io_space_pkg::access_kind_t acc_kind_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic [2:0] acc_bit_i,
    input wire logic [7:0] pin_a_i,
    input wire logic [7:0] pin_b_i,
    input wire logic [7:0] pin_c_i,
    input wire logic [7:0] pin_d_i,
    input wire logic [7:0] timer0_flag_set_i,
    input wire logic [7:0] timer1_flag_set_i,
    input wire logic [7:0] timer2_flag_set_i,
    input wire logic [7:0] pin_change_flag_set_i,
    input wire logic [7:0] ext_irq_flag_set_i,
    output logic resp_valid_o,
    output logic resp_hit_o,
    output logic [7:0] rdata_o,
    output logic bit_value_o,
    output logic [7:0] dir_a_o,
    output logic [7:0] out_a_o,
    output logic [7:0] dir_b_o,
    output logic [7:0] out_b_o,
    output logic [7:0] dir_c_o,
    output logic [7:0] out_c_o,
    output logic [7:0] dir_d_o,
    output logic [7:0] out_d_o,
    output logic [7:0] timer0_flags_o,
    output logic [7:0] timer1_flags_o,
    output logic [7:0] timer2_flags_o,
    output logic [7:0] pin_change_flags_o,
    output logic [7:0] ext_irq_flags_o,
    output logic [7:0] ext_irq_mask_o,
    output logic [7:0] nvm_control_o,
    output logic [7:0] nvm_data_o,
    output logic [7:0] nvm_addr_low_o,
    output logic [7:0] nvm_addr_high_o,
    output logic [7:0] prescaler_sync_o,
    output logic [7:0] timer0_ctrl_a_o,
    output logic [7:0] timer0_ctrl_b_o,
    output logic [7:0] timer0_count_o,
    output logic [7:0] timer0_cmp_a_o,
    output logic [7:0] timer0_cmp_b_o,
    output logic [7:0] spi_control_o
);
    localparam logic [5:0] FLAG_ADDR [`FLAG_REG_COUNT] = '{`IOA_TIMER0_FLAGS, `IOA_TIMER1_FLAGS,
        `IOA_TIMER2_FLAGS, `IOA_PIN_CHANGE_FLAGS, `IOA_EXT_IRQ_FLAGS};
    localparam logic [7:0] FLAG_MASK [`FLAG_REG_COUNT] = '{`MASK_TIMER0_FLAGS, `MASK_TIMER1_FLAGS,
        `MASK_TIMER2_FLAGS, `MASK_PIN_CHANGE_FLAGS, `MASK_EXT_IRQ_FLAGS};

    // writable bits of the plain storage registers; zero for pins, flags and reserved slots
    function automatic logic [7:0] write_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `MASK_NONE;
        unique case (a)
            `IOA_PORT_A_DIR, `IOA_PORT_A_OUT, `IOA_PORT_B_DIR, `IOA_PORT_B_OUT,
            `IOA_PORT_C_DIR, `IOA_PORT_C_OUT, `IOA_PORT_D_DIR, `IOA_PORT_D_OUT,
            `IOA_SCRATCH_0, `IOA_SCRATCH_1, `IOA_SCRATCH_2, `IOA_NVM_DATA, `IOA_NVM_ADDR_LOW,
            `IOA_TIMER0_COUNT, `IOA_TIMER0_CMP_A, `IOA_TIMER0_CMP_B, `IOA_SPI_CONTROL: m = `MASK_FULL;
            `IOA_EXT_IRQ_MASK: m = `MASK_EXT_IRQ_MASK;
            `IOA_NVM_CONTROL: m = `MASK_NVM_CONTROL;
            `IOA_NVM_ADDR_HIGH: m = `MASK_NVM_ADDR_HIGH;
            `IOA_PRESCALER_SYNC: m = `MASK_PRESCALER_SYNC;
            `IOA_TIMER0_CTRL_A: m = `MASK_TIMER0_CTRL_A;
            `IOA_TIMER0_CTRL_B: m = `MASK_TIMER0_CTRL_B;
            default: m = `MASK_NONE;
        endcase
        return m;
    endfunction

    logic [`IO_REG_COUNT-1:0][7:0] regs_ff;
    logic [`IO_REG_COUNT-1:0][7:0] nxt_regs;
    logic [`FLAG_REG_COUNT-1:0][7:0] flag_set;
    logic [`FLAG_REG_COUNT-1:0][7:0] flag_clear;
    logic [`FLAG_REG_COUNT-1:0][7:0] flag_val;
    logic resp_valid_ff;
    logic resp_hit_ff;
    logic [7:0] rdata_ff;
    logic bit_value_ff;
    logic nxt_resp_valid;
    logic nxt_resp_hit;
    logic [7:0] nxt_rdata;
    logic nxt_bit_value;
    logic in_range;
    logic [5:0] io_addr;
    logic [7:0] rd_val;
    logic [7:0] wr_val;
    logic wr_en;
    logic rd_en;
    logic stored;

    assign flag_set = {ext_irq_flag_set_i, pin_change_flag_set_i, timer2_flag_set_i,
        timer1_flag_set_i, timer0_flag_set_i};

    // address decode for both access forms
    always_comb begin
        in_range = 1'b0;
        io_addr = acc_addr_i[5:0];
        unique case (acc_kind_i)
            io_space_pkg::KIND_IO_IN, io_space_pkg::KIND_IO_OUT,
            io_space_pkg::KIND_BIT_SET, io_space_pkg::KIND_BIT_CLEAR, io_space_pkg::KIND_BIT_TEST: begin
                // a six-bit i/o address cannot encode the extended space
                in_range = (acc_addr_i[7:6] == 2'h0);
                io_addr = acc_addr_i[5:0];
            end
            io_space_pkg::KIND_DATA_LOAD, io_space_pkg::KIND_DATA_STORE: begin
                // below the window sit the working registers, above it the extended space
                in_range = (acc_addr_i >= `DATA_IO_BASE) && (acc_addr_i < `DATA_EXT_BASE);
                io_addr = 6'(acc_addr_i - `DATA_IO_BASE);
            end
            default: begin
                in_range = 1'b0;
                io_addr = acc_addr_i[5:0];
            end
        endcase
        stored = in_range && (io_addr <= `IOA_LAST);
    end

    // current value of the addressed register
    always_comb begin
        rd_val = `REG_RESET;
        if (stored) begin
            unique case (io_addr)
                `IOA_PORT_A_PIN: rd_val = pin_a_i;
                `IOA_PORT_B_PIN: rd_val = pin_b_i;
                `IOA_PORT_C_PIN: rd_val = pin_c_i;
                `IOA_PORT_D_PIN: rd_val = pin_d_i;
                default: rd_val = regs_ff[io_addr] & write_mask(io_addr);
            endcase
            for (int k = 0; k < `FLAG_REG_COUNT; k++) begin
                if (io_addr == FLAG_ADDR[k]) begin
                    rd_val = flag_val[k];
                end
            end
        end
    end

    // write data; bit operations rewrite the whole register from its read value
    always_comb begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_val = acc_wdata_i;
        unique case (acc_kind_i)
            io_space_pkg::KIND_IO_OUT, io_space_pkg::KIND_DATA_STORE: begin
                wr_en = 1'b1;
            end
            io_space_pkg::KIND_IO_IN, io_space_pkg::KIND_DATA_LOAD: begin
                rd_en = 1'b1;
            end
            io_space_pkg::KIND_BIT_SET: begin
                wr_en = (io_addr <= `IOA_BIT_LAST);
                wr_val = rd_val | (8'h01 << acc_bit_i);
            end
            io_space_pkg::KIND_BIT_CLEAR: begin
                wr_en = (io_addr <= `IOA_BIT_LAST);
                wr_val = rd_val & ~(8'h01 << acc_bit_i);
            end
            io_space_pkg::KIND_BIT_TEST: begin
                rd_en = (io_addr <= `IOA_BIT_LAST);
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
        wr_en = wr_en && acc_valid_i && stored;
        rd_en = rd_en && acc_valid_i && stored;
    end

    // storage registers keep reserved bits at zero
    always_comb begin
        nxt_regs = regs_ff;
        if (wr_en) begin
            nxt_regs[io_addr] = (regs_ff[io_addr] & ~write_mask(io_addr)) | (wr_val & write_mask(io_addr));
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regs_ff <= '0;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    generate
        for (genvar g = 0; g < `FLAG_REG_COUNT; g++) begin : gen_flags
            // a written one clears; a bit operation clears each flag read as set, except the bit that a bit clear names
            assign flag_clear[g] = (wr_en && io_addr == FLAG_ADDR[g]) ? wr_val : `MASK_NONE;
            w1c_flag_reg #(
                .MASK(FLAG_MASK[g])
            ) u_flag (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .set_i(flag_set[g]),
                .clear_i(flag_clear[g]),
                .flags_o(flag_val[g])
            );
        end
    endgenerate

    // answer registered at the decoding edge
    always_comb begin
        nxt_resp_valid = acc_valid_i;
        nxt_resp_hit = acc_valid_i && stored;
        nxt_rdata = rd_en ? rd_val : `REG_RESET;
        nxt_bit_value = (rd_en && acc_kind_i == io_space_pkg::KIND_BIT_TEST) ? rd_val[acc_bit_i] : 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_valid_ff <= 1'b0;
            resp_hit_ff <= 1'b0;
            rdata_ff <= `REG_RESET;
            bit_value_ff <= 1'b0;
        end else begin
            resp_valid_ff <= nxt_resp_valid;
            resp_hit_ff <= nxt_resp_hit;
            rdata_ff <= nxt_rdata;
            bit_value_ff <= nxt_bit_value;
        end
    end

    assign resp_valid_o = resp_valid_ff;
    assign resp_hit_o = resp_hit_ff;
    assign rdata_o = rdata_ff;
    assign bit_value_o = bit_value_ff;
    assign dir_a_o = regs_ff[`IOA_PORT_A_DIR];
    assign out_a_o = regs_ff[`IOA_PORT_A_OUT];
    assign dir_b_o = regs_ff[`IOA_PORT_B_DIR];
    assign out_b_o = regs_ff[`IOA_PORT_B_OUT];
    assign dir_c_o = regs_ff[`IOA_PORT_C_DIR];
    assign out_c_o = regs_ff[`IOA_PORT_C_OUT];
    assign dir_d_o = regs_ff[`IOA_PORT_D_DIR];
    assign out_d_o = regs_ff[`IOA_PORT_D_OUT];
    assign timer0_flags_o = flag_val[0];
    assign timer1_flags_o = flag_val[1];
    assign timer2_flags_o = flag_val[2];
    assign pin_change_flags_o = flag_val[3];
    assign ext_irq_flags_o = flag_val[4];
    assign ext_irq_mask_o = regs_ff[`IOA_EXT_IRQ_MASK];
    assign nvm_control_o = regs_ff[`IOA_NVM_CONTROL];
    assign nvm_data_o = regs_ff[`IOA_NVM_DATA];
    assign nvm_addr_low_o = regs_ff[`IOA_NVM_ADDR_LOW];
    assign nvm_addr_high_o = regs_ff[`IOA_NVM_ADDR_HIGH];
    assign prescaler_sync_o = regs_ff[`IOA_PRESCALER_SYNC];
    assign timer0_ctrl_a_o = regs_ff[`IOA_TIMER0_CTRL_A];
    assign timer0_ctrl_b_o = regs_ff[`IOA_TIMER0_CTRL_B];
    assign timer0_count_o = regs_ff[`IOA_TIMER0_COUNT];
    assign timer0_cmp_a_o = regs_ff[`IOA_TIMER0_CMP_A];
    assign timer0_cmp_b_o = regs_ff[`IOA_TIMER0_CMP_B];
    assign spi_control_o = regs_ff[`IOA_SPI_CONTROL];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_high_bit_op;
        acc_valid_i && acc_addr_i[7:6] == 2'h0 && acc_addr_i[5:0] > `IOA_BIT_LAST &&
        (acc_kind_i == io_space_pkg::KIND_BIT_SET || acc_kind_i == io_space_pkg::KIND_BIT_CLEAR);
    endsequence
    sequence s_flag_write_quiet;
        acc_valid_i && acc_kind_i == io_space_pkg::KIND_IO_OUT && acc_addr_i[5:0] == `IOA_TIMER0_FLAGS &&
        acc_addr_i[7:6] == 2'h0 && timer0_flag_set_i == 8'h00;
    endsequence
    sequence s_flag_bit_op;
        acc_valid_i && acc_kind_i == io_space_pkg::KIND_BIT_SET && acc_addr_i == 8'(`IOA_EXT_IRQ_FLAGS) &&
        ext_irq_flag_set_i == 8'h00;
    endsequence

    AST_HIGH_BIT_OP_IGNORED: assert property (s_high_bit_op |=> $stable(regs_ff))
        else $error("bit operation above 0x1F changed a register");
    AST_BIT_TEST_VALUE: assert property (acc_valid_i && acc_kind_i == io_space_pkg::KIND_BIT_TEST &&
        acc_addr_i <= 8'(`IOA_BIT_LAST) |=>
        bit_value_o == 1'($past(rd_val) >> $past(acc_bit_i)) && resp_valid_o)
        else $error("bit test returned the wrong value");
    AST_W1C_CLEARS: assert property (s_flag_write_quiet |=> (timer0_flags_o & $past(acc_wdata_i)) == 8'h00)
        else $error("written one did not clear a flag");
    AST_W1C_ZERO_KEEPS: assert property (s_flag_write_quiet ##0 (acc_wdata_i == 8'h00) |=>
        timer0_flags_o == $past(timer0_flags_o))
        else $error("written zero changed a flag");
    AST_RMW_CLEARS_SET_FLAGS: assert property (s_flag_bit_op |=> ext_irq_flags_o == 8'h00)
        else $error("bit operation did not clear flags read as set");
    AST_IO_WRITE_DIRECT: assert property (acc_valid_i && acc_kind_i == io_space_pkg::KIND_IO_OUT &&
        acc_addr_i == 8'(`IOA_SPI_CONTROL) |=> spi_control_o == $past(acc_wdata_i))
        else $error("i/o write did not land at its i/o address");
    AST_DATA_OFFSET: assert property (acc_valid_i && acc_kind_i == io_space_pkg::KIND_DATA_STORE &&
        acc_addr_i == 8'(`IOA_PORT_B_OUT) + `DATA_IO_BASE |=> out_b_o == $past(acc_wdata_i))
        else $error("data-space store missed the 0x20 offset");
    AST_EXT_NOT_HERE: assert property (acc_valid_i && acc_addr_i >= `DATA_EXT_BASE |=>
        $stable(regs_ff) && !resp_hit_o && rdata_o == 8'h00)
        else $error("extended address touched the i/o registers");
    AST_RESERVED_READS_ZERO: assert property (acc_valid_i && acc_kind_i == io_space_pkg::KIND_IO_IN &&
        acc_addr_i == 8'h29 |=> rdata_o == 8'h00 ##1 rdata_o == 8'h00 || resp_valid_o)
        else $error("reserved address read not zero");
    AST_ONE_CYCLE: assert property (acc_valid_i |=>
        resp_valid_o && (!$past(rd_en) || rdata_o == $past(rd_val)))
        else $error("access not answered in one cycle");
endmodule

// File: design/io_space_map.svh
// address map, field masks and reset values of the i/o register space decoder
`ifndef IO_SPACE_MAP_SVH
`define IO_SPACE_MAP_SVH

`define IOA_PORT_A_PIN 6'h00
`define IOA_PORT_A_DIR 6'h01
`define IOA_PORT_A_OUT 6'h02
`define IOA_PORT_B_PIN 6'h03
`define IOA_PORT_B_DIR 6'h04
`define IOA_PORT_B_OUT 6'h05
`define IOA_PORT_C_PIN 6'h06
`define IOA_PORT_C_DIR 6'h07
`define IOA_PORT_C_OUT 6'h08
`define IOA_PORT_D_PIN 6'h09
`define IOA_PORT_D_DIR 6'h0A
`define IOA_PORT_D_OUT 6'h0B
`define IOA_TIMER0_FLAGS 6'h15
`define IOA_TIMER1_FLAGS 6'h16
`define IOA_TIMER2_FLAGS 6'h17
`define IOA_PIN_CHANGE_FLAGS 6'h1B
`define IOA_EXT_IRQ_FLAGS 6'h1C
`define IOA_EXT_IRQ_MASK 6'h1D
`define IOA_SCRATCH_0 6'h1E
`define IOA_NVM_CONTROL 6'h1F
`define IOA_NVM_DATA 6'h20
`define IOA_NVM_ADDR_LOW 6'h21
`define IOA_NVM_ADDR_HIGH 6'h22
`define IOA_PRESCALER_SYNC 6'h23
`define IOA_TIMER0_CTRL_A 6'h24
`define IOA_TIMER0_CTRL_B 6'h25
`define IOA_TIMER0_COUNT 6'h26
`define IOA_TIMER0_CMP_A 6'h27
`define IOA_TIMER0_CMP_B 6'h28
`define IOA_SCRATCH_1 6'h2A
`define IOA_SCRATCH_2 6'h2B
`define IOA_SPI_CONTROL 6'h2C

// highest stored i/o address and the bit-accessible limit
`define IOA_LAST 6'h2C
`define IOA_BIT_LAST 6'h1F
`define IO_REG_COUNT 45

// data-space window of the i/o registers and start of the extended space
`define DATA_IO_BASE 8'h20
`define DATA_EXT_BASE 8'h60

// implemented bits; reserved bits are zero in the mask
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define MASK_TIMER0_FLAGS 8'h07
`define MASK_TIMER1_FLAGS 8'h27
`define MASK_TIMER2_FLAGS 8'h07
`define MASK_PIN_CHANGE_FLAGS 8'h0F
`define MASK_EXT_IRQ_FLAGS 8'h07
`define MASK_EXT_IRQ_MASK 8'h07
`define MASK_NVM_CONTROL 8'h3F
`define MASK_NVM_ADDR_HIGH 8'h0F
`define MASK_PRESCALER_SYNC 8'h83
`define MASK_TIMER0_CTRL_A 8'hF3
`define MASK_TIMER0_CTRL_B 8'hCF

`define REG_RESET 8'h00
`define FLAG_REG_COUNT 5

`endif

// File: design/io_space_pkg.sv
// types shared by the i/o register space decoder
package io_space_pkg;
    typedef enum logic [2:0] {
        KIND_IO_IN = 3'h0,
        KIND_IO_OUT = 3'h1,
        KIND_DATA_LOAD = 3'h2,
        KIND_DATA_STORE = 3'h3,
        KIND_BIT_SET = 3'h4,
        KIND_BIT_CLEAR = 3'h5,
        KIND_BIT_TEST = 3'h6
    } access_kind_t;
endpackage

// File: design/w1c_flag_reg.sv
// one status flag register: hardware sets, writing one clears
`timescale 1ns/1ps
`include "io_space_map.svh"

module w1c_flag_reg #(
    parameter logic [7:0] MASK = `MASK_FULL
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clear_i,
    output logic [7:0] flags_o
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    always_comb begin
        // set after clear, so an event in the clearing cycle survives
        nxt_flags = ((flags_ff & ~clear_i) | set_i) & MASK;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_ff <= `REG_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_o = flags_ff;
endmodule

// File: tb/core_model.sv
// processor core model: issues one register access at a time and keeps the response
`timescale 1ns/1ps
module core_model (
    input wire logic clock_i,
    input wire logic resp_valid_i,
    input wire logic resp_hit_i,
    input wire logic [7:0] rdata_i,
    input wire logic bit_value_i,
    output logic acc_valid_o,
    output io_space_pkg::access_kind_t acc_kind_o,
    output logic [7:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    output logic [2:0] acc_bit_o
);
    logic last_valid;
    logic last_hit;
    logic [7:0] last_rdata;
    logic last_bit;

    initial begin
        acc_valid_o = 1'b0;
        acc_kind_o = io_space_pkg::KIND_IO_IN;
        acc_addr_o = 8'h00;
        acc_wdata_o = 8'h00;
        acc_bit_o = 3'h0;
    end

    // load/store reach an i/o register at its i/o address plus the window base
    function automatic logic [7:0] data_addr(input logic [7:0] io_addr);
        return io_addr + 8'h20;
    endfunction

    // request held from one edge to the taking edge, response read in the cycle after
    task automatic access(input io_space_pkg::access_kind_t kind, input logic [7:0] addr,
                          input logic [7:0] wdata, input logic [2:0] bit_no);
        @(posedge clock_i);
        acc_valid_o <= 1'b1;
        acc_kind_o <= kind;
        acc_addr_o <= addr;
        acc_wdata_o <= wdata;
        acc_bit_o <= bit_no;
        @(posedge clock_i);
        acc_valid_o <= 1'b0;
        // idle data bus shows no stale value
        acc_wdata_o <= ~wdata;
        acc_addr_o <= ~addr;
        #1;
        last_valid = resp_valid_i;
        last_hit = resp_hit_i;
        last_rdata = rdata_i;
        last_bit = bit_value_i;
    endtask
endmodule

// File: tb/testbench.sv
// self-checking testbench of the i/o register space decoder
`timescale 1ns/1ps
module testbench;
    logic clock_i;
    logic rst_n_i;
    logic acc_valid;
    io_space_pkg::access_kind_t acc_kind;
    logic [7:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [2:0] acc_bit;
    logic [7:0] pin_a, pin_b, pin_c, pin_d;
    logic [7:0] fs0, fs1, fs2, fsp, fse;
    logic resp_valid, resp_hit, bit_value;
    logic [7:0] rdata, dir_a, out_b, f0, f1, f2, fp, fe, irq_mask, nvm_ctl, nvm_data, spi_ctl;
    logic [7:0] out_a, dir_b, dir_c, out_c, dir_d, out_d, addr_lo, addr_hi, presc, t0a, t0b, t0cnt, t0ca, t0cb;
    logic [7:0] mirror [14];
    // position in rw_addr of each of the 14 registers whose outputs are copied into mirror, in the order of mirror
    int mirror_idx [14] = '{1, 2, 4, 5, 6, 7, 12, 13, 14, 15, 16, 17, 18, 19};
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] rw_addr [23] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h1D, 8'h1E, 8'h1F,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2C};
    logic [7:0] rw_mask [23] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'h3F,
        8'hFF, 8'hFF, 8'h0F, 8'h83, 8'hF3, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    io_register_space_decoder dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .acc_valid_i(acc_valid),
        .acc_kind_i(acc_kind), .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .acc_bit_i(acc_bit),
        .pin_a_i(pin_a), .pin_b_i(pin_b), .pin_c_i(pin_c), .pin_d_i(pin_d), .timer0_flag_set_i(fs0),
        .timer1_flag_set_i(fs1), .timer2_flag_set_i(fs2), .pin_change_flag_set_i(fsp),
        .ext_irq_flag_set_i(fse), .resp_valid_o(resp_valid), .resp_hit_o(resp_hit), .rdata_o(rdata),
        .bit_value_o(bit_value), .dir_a_o(dir_a), .out_a_o(out_a), .dir_b_o(dir_b), .out_b_o(out_b),
        .dir_c_o(dir_c), .out_c_o(out_c), .dir_d_o(dir_d), .out_d_o(out_d), .timer0_flags_o(f0),
        .timer1_flags_o(f1), .timer2_flags_o(f2),
        .pin_change_flags_o(fp), .ext_irq_flags_o(fe), .ext_irq_mask_o(irq_mask), .nvm_control_o(nvm_ctl),
        .nvm_data_o(nvm_data), .nvm_addr_low_o(addr_lo), .nvm_addr_high_o(addr_hi), .prescaler_sync_o(presc),
        .timer0_ctrl_a_o(t0a), .timer0_ctrl_b_o(t0b), .timer0_count_o(t0cnt), .timer0_cmp_a_o(t0ca),
        .timer0_cmp_b_o(t0cb), .spi_control_o(spi_ctl));

    core_model core (.clock_i(clock_i), .resp_valid_i(resp_valid), .resp_hit_i(resp_hit), .rdata_i(rdata),
        .bit_value_i(bit_value), .acc_valid_o(acc_valid), .acc_kind_o(acc_kind), .acc_addr_o(acc_addr),
        .acc_wdata_o(acc_wdata), .acc_bit_o(acc_bit));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic acc(input io_space_pkg::access_kind_t k, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] b);
        core.access(k, a, d, b);
        check1("resp_valid", 1'b1, core.last_valid);
    endtask

    // ld selects the data-space form of the access
    task automatic rd(input logic ld, input logic [7:0] a, input logic [7:0] exp);
        if (ld) begin
            acc(io_space_pkg::KIND_DATA_LOAD, a, 8'h00, 3'h0);
        end else begin
            acc(io_space_pkg::KIND_IO_IN, a, 8'h00, 3'h0);
        end
        check8("rdata", exp, core.last_rdata);
    endtask

    task automatic wr(input logic st, input logic [7:0] a, input logic [7:0] d);
        if (st) begin
            acc(io_space_pkg::KIND_DATA_STORE, a, d, 3'h0);
        end else begin
            acc(io_space_pkg::KIND_IO_OUT, a, d, 3'h0);
        end
    endtask

    task automatic bit_test(input logic [7:0] a, input logic [2:0] b, input logic exp);
        acc(io_space_pkg::KIND_BIT_TEST, a, 8'h00, b);
        check1("bit_value", exp, core.last_bit);
    endtask

    initial begin
        rst_n_i = 1'b0;
        {fs0, fs1, fs2, fsp, fse} = '0;
        pin_a = 8'h11;
        pin_b = 8'h20;
        pin_c = 8'h33;
        pin_d = 8'h44;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // reset value, then store through the data window and read back both ways
        for (int i = 0; i < 23; i++) begin
            rd(1'b0, rw_addr[i], 8'h00);
            wr(1'b1, core.data_addr(rw_addr[i]), 8'hA5 & rw_mask[i]);
            rd(1'b0, rw_addr[i], 8'hA5 & rw_mask[i]);
            rd(1'b1, core.data_addr(rw_addr[i]), 8'hA5 & rw_mask[i]);
        end
        check8("spi_control_o", 8'hA5, spi_ctl);
        check8("out_b_o", 8'hA5, out_b);
        mirror = '{out_a, dir_b, dir_c, out_c, dir_d, out_d, addr_lo, addr_hi,
            presc, t0a, t0b, t0cnt, t0ca, t0cb};
        for (int i = 0; i < 14; i++) begin
            check8("register output", 8'hA5 & rw_mask[mirror_idx[i]], mirror[i]);
        end
        wr(1'b0, 8'h2C, 8'h5A);
        check8("spi_control_o", 8'h5A, spi_ctl);
        // the one kind code that the enum leaves free must miss and read zero
        acc(io_space_pkg::access_kind_t'(3'h7), 8'h2C, 8'h00, 3'h0);
        check1("hit", 1'b0, core.last_hit);
        check8("rdata", 8'h00, core.last_rdata);
        check8("spi_control_o", 8'h5A, spi_ctl);
        $display("test register map done");
        rd(1'b0, 8'h00, 8'h11);
        rd(1'b0, 8'h06, 8'h33);
        rd(1'b1, 8'h23, 8'h20);
        rd(1'b1, 8'h29, 8'h44);
        $display("test pin inputs done");
        // reserved bits written as ones on purpose: only implemented bits may stick
        wr(1'b0, 8'h1D, 8'hFF);
        check8("ext_irq_mask_o", 8'h07, irq_mask);
        rd(1'b0, 8'h0C, 8'h00);
        check1("hit", 1'b1, core.last_hit);
        rd(1'b0, 8'h29, 8'h00);
        rd(1'b1, 8'h1F, 8'h00);
        check1("hit", 1'b0, core.last_hit);
        rd(1'b1, 8'h60, 8'h00);
        check1("hit", 1'b0, core.last_hit);
        rd(1'b0, 8'h40, 8'h00);
        check1("hit", 1'b0, core.last_hit);
        $display("test reserved and misses done");
        @(posedge clock_i);
        {fs0, fs1, fs2, fsp, fse} <= {5{8'hFF}};
        @(posedge clock_i);
        {fs0, fs1, fs2, fsp, fse} <= '0;
        rd(1'b0, 8'h16, 8'h27);
        wr(1'b0, 8'h15, 8'h01);
        check8("timer0_flags_o", 8'h06, f0);
        wr(1'b0, 8'h15, 8'h00);
        check8("timer0_flags_o", 8'h06, f0);
        wr(1'b1, 8'h3B, 8'h03);
        check8("pin_change_flags_o", 8'h0C, fp);
        acc(io_space_pkg::KIND_BIT_SET, 8'h1C, 8'h00, 3'h0);
        check8("ext_irq_flags_o", 8'h00, fe);
        acc(io_space_pkg::KIND_BIT_CLEAR, 8'h17, 8'h00, 3'h1);
        check8("timer2_flags_o", 8'h02, f2);
        check8("timer1_flags_o", 8'h27, f1);
        $display("test status flags done");
        acc(io_space_pkg::KIND_BIT_SET, 8'h01, 8'h00, 3'h1);
        check8("dir_a_o", 8'hA7, dir_a);
        acc(io_space_pkg::KIND_BIT_CLEAR, 8'h01, 8'h00, 3'h7);
        check8("dir_a_o", 8'h27, dir_a);
        acc(io_space_pkg::KIND_BIT_SET, 8'h1F, 8'h00, 3'h1);
        check8("nvm_control_o", 8'h27, nvm_ctl);
        acc(io_space_pkg::KIND_BIT_SET, 8'h20, 8'h00, 3'h1);
        check8("nvm_data_o", 8'hA5, nvm_data);
        acc(io_space_pkg::KIND_BIT_CLEAR, 8'h20, 8'h00, 3'h0);
        check8("nvm_data_o", 8'hA5, nvm_data);
        bit_test(8'h03, 3'h5, 1'b1);
        bit_test(8'h03, 3'h4, 1'b0);
        bit_test(8'h1F, 3'h0, 1'b1);
        bit_test(8'h20, 3'h0, 1'b0);
        $display("test bit operations done");
        end_of_test();
    end

    // the whole sequence needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clock_i);
        mismatches++;
        end_of_test();
    end
endmodule
